/* src/plsp_pkg.sv */
// shared constants, types and the line-length decode for the program-line sequencer
package plsp_pkg;
   // ---------------------------------------------------------------
   // program store geometry
   // ---------------------------------------------------------------
   localparam int NUM_LINES   = 26;
   localparam int MAX_STEPS   = 15;
   localparam int TOTAL_STEPS = 242;
   localparam int NUM_SEL     = 2;
   localparam int LINE_W      = 5;
   localparam int STEP_W      = 4;
   localparam logic [LINE_W-1:0] LAST_LINE = 5'h19;
   localparam logic [STEP_W-1:0] FIRST_STEP = 4'h0;

   // ---------------------------------------------------------------
   // line groups: first line index past each group, and its length
   // ---------------------------------------------------------------
   localparam logic [LINE_W-1:0] GRP_A_END = 5'h06;
   localparam logic [LINE_W-1:0] GRP_B_END = 5'h0a;
   localparam logic [LINE_W-1:0] GRP_C_END = 5'h0e;
   localparam logic [LINE_W-1:0] GRP_D_END = 5'h12;
   localparam logic [LINE_W-1:0] GRP_E_END = 5'h16;
   localparam logic [STEP_W-1:0] LEN_A     = 4'hf;
   localparam logic [STEP_W-1:0] LEN_B     = 4'hc;
   localparam logic [STEP_W-1:0] LEN_C     = 4'ha;
   localparam logic [STEP_W-1:0] LEN_D     = 4'h8;
   localparam logic [STEP_W-1:0] LEN_E     = 4'h5;
   localparam logic [STEP_W-1:0] LEN_F     = 4'h3;

   // ---------------------------------------------------------------
   // console key positions in the synchronised key vector
   // ---------------------------------------------------------------
   localparam int NUM_KEYS = 4;
   localparam int KEY_RUN  = 0;
   localparam int KEY_SS   = 1;
   localparam int KEY_ADV  = 2;
   localparam int KEY_HALT = 3;

   typedef enum logic [1:0] {
      PLSP_IDLE,
      PLSP_RUN,
      PLSP_HALT
   } plsp_state_e;

   // number of steps held by a line
   function automatic logic [STEP_W-1:0] plsp_line_len(input logic [LINE_W-1:0] ln);
      if (ln < GRP_A_END) return LEN_A;
      if (ln < GRP_B_END) return LEN_B;
      if (ln < GRP_C_END) return LEN_C;
      if (ln < GRP_D_END) return LEN_D;
      if (ln < GRP_E_END) return LEN_E;
      return LEN_F;
   endfunction
endpackage

/* src/plsp_key_if.sv */
// synchronised console key levels and press pulses
`timescale 1ns/1ns
interface plsp_key_if #(parameter int N = 4);
   logic [N-1:0] held;
   logic [N-1:0] press;
   modport src (output held, output press);
   modport dst (input held, input press);
endinterface

/* src/plsp_key_sync.sv */
// two-flop synchroniser and press detector for the console keys
`timescale 1ns/1ns
module plsp_key_sync #(
   parameter int N = 4
) (
   // clock and reset
   input  wire logic         i_ref_clk,
   input  wire logic         i_reset,
   // raw keys
   input  wire logic [N-1:0] i_key,
   // clean keys
   plsp_key_if.src           o_keys
);
   logic [N-1:0] meta;
   logic [N-1:0] sync;
   logic [N-1:0] prev;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= i_key;
         sync <= meta;
         prev <= sync;
      end
   end

   assign o_keys.held  = sync;
   assign o_keys.press = sync & ~prev;
endmodule

/* src/plsp_sequencer.sv */
// program-line sequencer and operator console logic
`timescale 1ns/1ns
module plsp_sequencer #(
   parameter int NUM_LINES = plsp_pkg::NUM_LINES,
   parameter int MAX_STEPS = plsp_pkg::MAX_STEPS
) (
   // clock and reset
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_reset,
   // console keys (pins)
   input  wire logic                         i_run_begin_key,
   input  wire logic                         i_single_step_latch_key,
   input  wire logic                         i_step_advance_key,
   input  wire logic                         i_halt_key,
   // processor side
   input  wire logic                         i_line_sel_valid,
   input  wire logic [plsp_pkg::LINE_W-1:0]  i_line_sel,
   input  wire logic                         i_step_ready,
   input  wire logic                         i_bad_transfer,
   input  wire logic [plsp_pkg::NUM_SEL-1:0] i_sel_set,
   input  wire logic [plsp_pkg::NUM_SEL-1:0] i_sel_clear,
   output logic                              o_step_fire,
   output logic [plsp_pkg::STEP_W-1:0]       o_step_index,
   // console lamps
   output logic [NUM_LINES-1:0]              o_line_lamp,
   output logic [MAX_STEPS-1:0]              o_step_lamp,
   output logic [plsp_pkg::NUM_SEL-1:0]      o_selector_lamp,
   output logic                              o_run_begin_lamp,
   output logic                              o_single_step_lamp,
   output logic                              o_step_advance_lamp,
   output logic                              o_halt_lamp,
   output logic                              o_error_stop
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (NUM_LINES != plsp_pkg::NUM_LINES || MAX_STEPS != plsp_pkg::MAX_STEPS) begin : g_geom_chk
      $error("line geometry is fixed by the group table");
   end

   // ---------------------------------------------------------------
   // key synchronisation
   // ---------------------------------------------------------------
   plsp_key_if #(.N(plsp_pkg::NUM_KEYS)) kif ();

   plsp_key_sync #(.N(plsp_pkg::NUM_KEYS)) u_keys (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_key     ({i_halt_key, i_step_advance_key, i_single_step_latch_key, i_run_begin_key}),
      .o_keys    (kif.src)
   );

   wire run_press  = kif.press[plsp_pkg::KEY_RUN];
   wire ss_press   = kif.press[plsp_pkg::KEY_SS];
   wire adv_press  = kif.press[plsp_pkg::KEY_ADV];
   wire halt_press = kif.press[plsp_pkg::KEY_HALT];

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   plsp_pkg::plsp_state_e                 state;
   plsp_pkg::plsp_state_e                 next_state;
   logic                                  line_active;
   logic [plsp_pkg::LINE_W-1:0]           active_line;
   logic [plsp_pkg::STEP_W-1:0]           step;
   logic                                  ss_latch;
   logic                                  step_mode;
   logic                                  power_fresh;
   logic                                  err;
   logic [plsp_pkg::NUM_SEL-1:0]          sel;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire                          running   = (state == plsp_pkg::PLSP_RUN);
   wire [plsp_pkg::STEP_W-1:0]   cur_len   = plsp_pkg::plsp_line_len(active_line);
   wire                          last_step = (step == cur_len - 4'h1);
   wire                          sel_ok    = i_line_sel <= plsp_pkg::LAST_LINE;
   wire                          take_sel  = i_line_sel_valid & sel_ok & ~running;
   wire                          halt_evt  = running & (halt_press | i_bad_transfer);
   wire                          start_ok  = run_press & ~running & line_active & ~err;
   wire                          auto_fire = running & ~step_mode & i_step_ready & ~halt_evt;
   wire                          man_fire  = running & step_mode & ss_latch & adv_press & ~halt_evt;
   wire                          fire      = auto_fire | man_fire;
   wire                          line_end  = fire & last_step;
   wire                          sel_reset = run_press & power_fresh;

   always_comb begin
      next_state = state;
      unique case (state)
         plsp_pkg::PLSP_IDLE: if (start_ok) next_state = plsp_pkg::PLSP_RUN;
         plsp_pkg::PLSP_RUN: begin
            if (halt_evt) next_state = plsp_pkg::PLSP_HALT;
            else if (line_end) next_state = plsp_pkg::PLSP_IDLE;
         end
         plsp_pkg::PLSP_HALT: if (start_ok) next_state = plsp_pkg::PLSP_RUN;
      endcase
   end

   wire next_line_active = take_sel | (line_active & ~line_end);
   wire [plsp_pkg::LINE_W-1:0] next_line = take_sel ? i_line_sel : active_line;
   wire [plsp_pkg::STEP_W-1:0] next_step =
      (take_sel | start_ok | line_end) ? plsp_pkg::FIRST_STEP :
      fire ? step + 4'h1 : step;
   wire next_ss_latch  = ss_latch ^ ss_press;
   wire next_step_mode = (ss_press & ~ss_latch) | (step_mode & ~(adv_press & ~ss_latch));
   wire [plsp_pkg::NUM_SEL-1:0] next_sel =
      i_sel_set | (sel & ~i_sel_clear & {plsp_pkg::NUM_SEL{~sel_reset}});
   wire next_err = err | i_bad_transfer;

   function automatic logic [NUM_LINES-1:0] line_lamps(input logic act,
                                                       input logic [plsp_pkg::LINE_W-1:0] ln);
      logic [NUM_LINES-1:0] l;
      l = '1;
      if (act) l[ln] = 1'b0;
      return l;
   endfunction

   function automatic logic [MAX_STEPS-1:0] step_lamps(input logic [plsp_pkg::STEP_W-1:0] s);
      logic [MAX_STEPS-1:0] l;
      l = '1;
      l[s] = 1'b0;
      return l;
   endfunction

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state       <= plsp_pkg::PLSP_IDLE;
         line_active <= 1'b0;
         active_line <= '0;
         step        <= plsp_pkg::FIRST_STEP;
         ss_latch    <= 1'b0;
         step_mode   <= 1'b0;
         power_fresh <= 1'b1;
         err         <= 1'b0;
         sel         <= '0;
      end else begin
         state       <= next_state;
         line_active <= next_line_active;
         active_line <= next_line;
         step        <= next_step;
         ss_latch    <= next_ss_latch;
         step_mode   <= next_step_mode;
         power_fresh <= power_fresh & ~run_press;
         err         <= next_err;
         sel         <= next_sel;
      end
   end

   // lamps follow the next state so they match the state registers, but the advance lamp and the run and halt key terms follow kif.held
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_step_fire         <= 1'b0;
         o_step_index        <= plsp_pkg::FIRST_STEP;
         o_line_lamp         <= '1;
         o_step_lamp         <= step_lamps(plsp_pkg::FIRST_STEP);
         o_selector_lamp     <= '0;
         o_run_begin_lamp    <= 1'b0;
         o_single_step_lamp  <= 1'b0;
         o_step_advance_lamp <= 1'b0;
         o_halt_lamp         <= 1'b0;
         o_error_stop        <= 1'b0;
      end else begin
         o_step_fire         <= fire;
         o_step_index        <= next_step;
         o_line_lamp         <= line_lamps(next_line_active, next_line);
         o_step_lamp         <= step_lamps(next_step);
         o_selector_lamp     <= next_sel;
         o_run_begin_lamp    <= (next_state == plsp_pkg::PLSP_RUN) | kif.held[plsp_pkg::KEY_RUN];
         o_single_step_lamp  <= next_ss_latch;
         o_step_advance_lamp <= kif.held[plsp_pkg::KEY_ADV];
         o_halt_lamp         <= next_err | kif.held[plsp_pkg::KEY_HALT];
         o_error_stop        <= next_err;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   sequence s_line_done;
      fire && last_step;
   endsequence

   sequence s_rewound;
      !line_active && step == plsp_pkg::FIRST_STEP && state == plsp_pkg::PLSP_IDLE;
   endsequence

   sequence s_select;
      i_line_sel_valid && !running;
   endsequence

   property p_line_range;
      $countones(~o_line_lamp) <= 1 && active_line <= plsp_pkg::LAST_LINE;
   endproperty
   a_line_range: assert property (p_line_range) else $error("more than one line lamp dark");

   property p_step_bound;
      line_active |-> step < plsp_pkg::plsp_line_len(active_line);
   endproperty
   a_step_bound: assert property (p_step_bound) else $error("step beyond line length");

   property p_line_dark;
      s_select ##0 sel_ok |=> !o_line_lamp[$past(i_line_sel)] && line_active;
   endproperty
   a_line_dark: assert property (p_line_dark) else $error("selected line lamp still lit");

   property p_step_lamp;
      $countones(o_step_lamp) == MAX_STEPS - 1 && !o_step_lamp[step];
   endproperty
   a_step_lamp: assert property (p_step_lamp) else $error("step lamps do not mark next step");

   property p_sel_lamp;
      i_sel_set[0] |=> o_selector_lamp[0];
   endproperty
   a_sel_lamp: assert property (p_sel_lamp) else $error("transferred selector lamp dark");

   property p_sel_reset;
      sel_reset && i_sel_set == '0 |=> o_selector_lamp == '0;
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("first start left a selector set");

   property p_run_lamp;
      running |-> o_run_begin_lamp;
   endproperty
   a_run_lamp: assert property (p_run_lamp) else $error("run lamp dark while running");

   property p_restart;
      state == plsp_pkg::PLSP_HALT && start_ok |=> running && step == plsp_pkg::FIRST_STEP;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not begin at first step");

   property p_ss_toggle;
      ss_press |=> o_single_step_lamp != $past(o_single_step_lamp);
   endproperty
   a_ss_toggle: assert property (p_ss_toggle) else $error("single-step lamp did not toggle");

   property p_no_auto;
      running && step_mode && !adv_press |=> step == $past(step) && !o_step_fire;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("step advanced alone in single-step");

   property p_one_step;
      man_fire && !last_step |=> (step - $past(step)) == 4'h1 ##1 step == $past(step, 1);
   endproperty
   a_one_step: assert property (p_one_step) else $error("advance press moved wrong distance");

   property p_resume;
      adv_press && !ss_latch && !ss_press |=> !step_mode;
   endproperty
   a_resume: assert property (p_resume) else $error("continuous mode not restored");

   property p_halt;
      running && halt_press |=> state == plsp_pkg::PLSP_HALT && !o_run_begin_lamp[*1] ##1 !o_step_fire;
   endproperty
   a_halt: assert property (p_halt) else $error("halt key did not stop");

   property p_error;
      i_bad_transfer |=> (o_halt_lamp && o_error_stop)[*3];
   endproperty
   a_error: assert property (p_error) else $error("error lamp not held");

   property p_key_lamp;
      kif.held[plsp_pkg::KEY_ADV] |=> o_step_advance_lamp;
   endproperty
   a_key_lamp: assert property (p_key_lamp) else $error("advance lamp dark while held");

   property p_line_end;
      s_line_done |=> s_rewound ##0 o_line_lamp == '1;
   endproperty
   a_line_end: assert property (p_line_end) else $error("line did not end cleanly");

   property p_auto_step;
      running && !step_mode && i_step_ready && !halt_press && !i_bad_transfer |=> o_step_fire;
   endproperty
   a_auto_step: assert property (p_auto_step) else $error("continuous mode did not step");

   property p_halt_key_lamp;
      kif.held[plsp_pkg::KEY_HALT] |=> o_halt_lamp;
   endproperty
   a_halt_key_lamp: assert property (p_halt_key_lamp) else $error("halt lamp dark while held");
endmodule

/* tb/plsp_operator.sv */
// console operator model: presses keys, restarts lines and clears the machine
`timescale 1ns/1ns
module plsp_operator (
   // clock
   input  wire logic  i_ref_clk,
   // keys and machine clear
   output logic [3:0] o_key,
   output logic       o_reset
);
   initial begin
      o_key   = 4'h0;
      // machine held clear from power-up so no edge sees unknown state
      o_reset = 1'b1;
   end

   task automatic hold(input int k);
      @(negedge i_ref_clk);
      o_key[k] = 1'b1;
   endtask

   // the key is seen low for several cycles before any further press
   task automatic let_go(input int k);
      @(negedge i_ref_clk);
      o_key[k] = 1'b0;
      repeat (4) @(negedge i_ref_clk);
   endtask

   task automatic press(input int k);
      hold(k);
      repeat (4) @(negedge i_ref_clk);
      let_go(k);
   endtask

   // the run press itself rewinds the program elements to their first step as the line restarts
   task automatic restart();
      press(plsp_pkg::KEY_RUN);
   endtask

   // clear the machine before the failed operation is run again
   task automatic clear_machine();
      @(negedge i_ref_clk);
      o_reset = 1'b1;
      repeat (10) @(negedge i_ref_clk);
      o_reset = 1'b0;
      repeat (3) @(negedge i_ref_clk);
   endtask
endmodule

/* tb/program_line_sequencer_panel_test.sv */
// self-checking bench for the program-line sequencer
`timescale 1ns/1ns
module program_line_sequencer_panel_test;
   logic        i_ref_clk = 1'b0;
   logic        line_sel_valid = 1'b0;
   logic [4:0]  line_sel = 5'h00;
   logic        step_ready = 1'b0;
   logic        bad_xfer = 1'b0;
   logic [1:0]  sel_set = 2'h0;
   logic [1:0]  sel_clear = 2'h0;
   logic [3:0]  key;
   logic        rst;
   wire         step_fire;
   wire  [3:0]  step_index;
   wire  [25:0] line_lamp;
   wire  [14:0] step_lamp;
   wire  [1:0]  selector_lamp;
   wire         run_lamp, ss_lamp, adv_lamp, halt_lamp, error_stop;
   int          err_total = 0;
   int          num_checks = 0;
   int          fire_cnt = 0;
   int          lines [6] = '{0, 6, 10, 14, 18, 22};
   int          lens [6] = '{15, 12, 10, 8, 5, 3};

   always #5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) if (step_fire === 1'b1) fire_cnt <= fire_cnt + 1;

   plsp_operator op (.i_ref_clk(i_ref_clk), .o_key(key), .o_reset(rst));

   plsp_sequencer DUT (
      .i_ref_clk(i_ref_clk), .i_reset(rst),
      .i_run_begin_key(key[plsp_pkg::KEY_RUN]), .i_single_step_latch_key(key[plsp_pkg::KEY_SS]),
      .i_step_advance_key(key[plsp_pkg::KEY_ADV]), .i_halt_key(key[plsp_pkg::KEY_HALT]),
      .i_line_sel_valid(line_sel_valid), .i_line_sel(line_sel), .i_step_ready(step_ready),
      .i_bad_transfer(bad_xfer), .i_sel_set(sel_set), .i_sel_clear(sel_clear),
      .o_step_fire(step_fire), .o_step_index(step_index), .o_line_lamp(line_lamp),
      .o_step_lamp(step_lamp), .o_selector_lamp(selector_lamp), .o_run_begin_lamp(run_lamp),
      .o_single_step_lamp(ss_lamp), .o_step_advance_lamp(adv_lamp), .o_halt_lamp(halt_lamp),
      .o_error_stop(error_stop));

   // ------------------------------------------------------------------
   // comparison and closing
   // ------------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic select(input logic [4:0] l);
      @(negedge i_ref_clk);
      line_sel_valid = 1'b1;
      line_sel = l;
      @(negedge i_ref_clk);
      line_sel_valid = 1'b0;
   endtask

   task automatic pulse_ready(input int n);
      @(negedge i_ref_clk);
      step_ready = 1'b1;
      repeat (n) @(negedge i_ref_clk);
      step_ready = 1'b0;
   endtask

   // lets the line run out and judges the end state
   task automatic run_to_end(input int exp_fires);
      int n;
      step_ready = 1'b1;
      for (n = 0; n < 60 && run_lamp !== 1'b0; n++) @(negedge i_ref_clk);
      step_ready = 1'b0;
      if (n == 60) begin
         err_total++;
         $display("unexpected at %0t: line never ended", $time);
         give_verdict();
      end
      @(negedge i_ref_clk);
      chk_vec(fire_cnt, exp_fires, "fired steps");
      chk_vec(line_lamp, 32'h03ffffff, "line lamps after end");
      chk_vec(step_lamp, 32'h00007ffe, "step lamps after end");
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset_and_selectors();
      chk_vec(line_lamp, 32'h03ffffff, "line lamps at reset");
      chk_vec(step_lamp, 32'h00007ffe, "step lamps at reset");
      select(5'h1a);
      chk_vec(line_lamp, 32'h03ffffff, "out of range line");
      @(negedge i_ref_clk) sel_set = 2'h3;
      @(negedge i_ref_clk) sel_set = 2'h0;
      chk_vec(selector_lamp, 2'h3, "selectors set");
      @(negedge i_ref_clk) sel_clear = 2'h1;
      @(negedge i_ref_clk) sel_clear = 2'h0;
      chk_vec(selector_lamp, 2'h2, "selector one normal");
      op.press(plsp_pkg::KEY_RUN);
      chk_bit(run_lamp, 1'b0, "out of range line not started");
      chk_vec(selector_lamp, 2'h0, "first start clears selectors");
      @(negedge i_ref_clk) sel_set = 2'h1;
      @(negedge i_ref_clk) sel_set = 2'h0;
      op.press(plsp_pkg::KEY_RUN);
      chk_vec(selector_lamp, 2'h1, "later start keeps selectors");
   endtask

   task automatic t_all_groups();
      for (int g = 0; g < 6; g++) begin
         select(lines[g][4:0]);
         chk_vec(line_lamp, ~(32'h1 << lines[g]) & 32'h03ffffff, "selected line dark");
         chk_vec(step_index, 4'h0, "first step next");
         fire_cnt = 0;
         op.press(plsp_pkg::KEY_RUN);
         chk_bit(run_lamp, 1'b1, "run lamp while running");
         chk_vec(line_lamp, ~(32'h1 << lines[g]) & 32'h03ffffff, "lamp dark mid line");
         run_to_end(lens[g]);
      end
   endtask

   task automatic t_halt_restart();
      select(5'h00);
      fire_cnt = 0;
      op.press(plsp_pkg::KEY_RUN);
      pulse_ready(2);
      chk_vec(step_index, 4'h2, "two steps done");
      chk_vec(step_lamp, 32'h00007ffb, "step lamp of next step");
      op.hold(plsp_pkg::KEY_HALT);
      repeat (4) @(negedge i_ref_clk);
      chk_bit(halt_lamp, 1'b1, "halt key lamp");
      op.let_go(plsp_pkg::KEY_HALT);
      chk_bit(run_lamp, 1'b0, "halted");
      pulse_ready(3);
      chk_vec(fire_cnt, 2, "no steps while halted");
      op.restart();
      chk_vec(step_index, 4'h0, "restart at first step");
      fire_cnt = 0;
      run_to_end(15);
   endtask

   task automatic t_single_step();
      op.press(plsp_pkg::KEY_SS);
      chk_bit(ss_lamp, 1'b1, "latch on");
      select(5'h0e);
      fire_cnt = 0;
      op.press(plsp_pkg::KEY_RUN);
      pulse_ready(6);
      chk_vec(fire_cnt, 0, "no automatic steps");
      op.hold(plsp_pkg::KEY_ADV);
      repeat (4) @(negedge i_ref_clk);
      chk_bit(adv_lamp, 1'b1, "advance key lamp");
      op.let_go(plsp_pkg::KEY_ADV);
      chk_vec(fire_cnt, 1, "one step per press");
      chk_vec(step_index, 4'h1, "index moved one");
      op.press(plsp_pkg::KEY_SS);
      chk_bit(ss_lamp, 1'b0, "latch released");
      pulse_ready(3);
      chk_vec(fire_cnt, 1, "still stepping until advance");
      op.press(plsp_pkg::KEY_ADV);
      chk_vec(fire_cnt, 1, "leaving press fires nothing");
      run_to_end(8);
   endtask

   task automatic t_bad_transfer();
      select(5'h06);
      op.press(plsp_pkg::KEY_RUN);
      @(negedge i_ref_clk) bad_xfer = 1'b1;
      @(negedge i_ref_clk) bad_xfer = 1'b0;
      chk_bit(error_stop, 1'b1, "error latched");
      chk_bit(halt_lamp, 1'b1, "red halt lamp");
      fire_cnt = 0;
      pulse_ready(3);
      chk_vec(fire_cnt, 0, "stopped on error");
      op.press(plsp_pkg::KEY_RUN);
      chk_bit(run_lamp, 1'b0, "start refused on error");
      op.clear_machine();
      chk_bit(error_stop, 1'b0, "error cleared");
   endtask

   initial begin
      op.clear_machine();
      t_reset_and_selectors();
      t_all_groups();
      t_halt_restart();
      t_single_step();
      t_bad_transfer();
      give_verdict();
   end
endmodule
